/* logic/acdp_core.sv */
// Calibration datapath: offset, gain, range check, result store.
// Assumes filter samples and input_chopping_mode phase come from logic on clk.
//
// Implementation choices: the Avalon-MM interface to the registers and the register addresses.
module acdp_core (
  input wire logic clk,
  input wire logic srst,
  input acdp_pkg::acdp_filt_t filt,
  input wire logic input_chopping_mode_phase,
  input acdp_pkg::acdp_avl_req_t avs,
  output logic [31:0] readdata,
  output logic waitrequest,
  output logic signed [acdp_pkg::RES_W-1:0] conv_data,
  output logic conv_done,
  output logic range_overflow_flag,
  output logic excitation_swap,
  output logic irq
);
  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [3:0] ofs_shift(acdp_pkg::acdp_res_t r);
    unique case (r)
      acdp_pkg::ACDP_RES16: ofs_shift = acdp_pkg::OFS_SHIFT16;
      acdp_pkg::ACDP_RES20: ofs_shift = acdp_pkg::OFS_SHIFT20;
      default: ofs_shift = acdp_pkg::OFS_SHIFT24;
    endcase
  endfunction
  function automatic logic signed [acdp_pkg::RES_W-1:0] lim_max(
      acdp_pkg::acdp_res_t r);
    unique case (r)
      acdp_pkg::ACDP_RES16: lim_max = acdp_pkg::MAX16;
      acdp_pkg::ACDP_RES20: lim_max = acdp_pkg::MAX20;
      default: lim_max = acdp_pkg::MAX24;
    endcase
  endfunction
  function automatic logic signed [acdp_pkg::RES_W-1:0] lim_min(
      acdp_pkg::acdp_res_t r);
    unique case (r)
      acdp_pkg::ACDP_RES16: lim_min = acdp_pkg::MIN16;
      acdp_pkg::ACDP_RES20: lim_min = acdp_pkg::MIN20;
      default: lim_min = acdp_pkg::MIN24;
    endcase
  endfunction
  function automatic logic [31:0] be_merge(logic [31:0] old,
      logic [31:0] wd, logic [3:0] be);
    be_merge = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        be_merge[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
  endfunction

  // ****************************************
  // Register file and bus slave
  // ****************************************
  acdp_pkg::acdp_bus_t bus_state, next_bus_state;
  acdp_pkg::acdp_ctrl_t ctrl, next_ctrl;
  logic [acdp_pkg::HALF_W-1:0] offset_word_hi, next_offset_word_hi;
  logic [acdp_pkg::HALF_W-1:0] offset_word_lo, next_offset_word_lo;
  logic [acdp_pkg::HALF_W-1:0] gain_word_hi, next_gain_word_hi;
  logic [acdp_pkg::HALF_W-1:0] gain_word_lo, next_gain_word_lo;
  logic [1:0] irq_stat, next_irq_stat;
  logic [1:0] irq_mask, next_irq_mask;
  logic [31:0] next_readdata;
  logic [31:0] rd_mux;
  logic [31:0] wr_merged;
  logic wr_go;
  logic rd_go;
  logic [1:0] irq_set;
  logic signed [acdp_pkg::OFS_W-1:0] offset_val;
  logic [acdp_pkg::GAIN_W-1:0] gain_val;

  // One wait state: data latched in idle, handed over in ack
  assign waitrequest = (avs.read | avs.write) &
    (bus_state == acdp_pkg::ACDP_IDLE);
  assign wr_go = avs.write & (bus_state == acdp_pkg::ACDP_ACK);
  assign rd_go = avs.read & (bus_state == acdp_pkg::ACDP_ACK);
  assign offset_val = $signed({offset_word_hi, offset_word_lo});
  assign gain_val = {gain_word_hi, gain_word_lo};
  assign irq = |(irq_stat & irq_mask);
  assign wr_merged = be_merge(rd_mux, avs.writedata, avs.byteenable);

  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (avs.address)
      acdp_pkg::ADDR_CTRL: rd_mux[acdp_pkg::CTL_W-1:0] = ctrl;
      acdp_pkg::ADDR_STAT:
        rd_mux[acdp_pkg::STAT_OVF_BIT] = range_overflow_flag;
      acdp_pkg::ADDR_OFS_HI: rd_mux[15:0] = offset_word_hi;
      acdp_pkg::ADDR_OFS_LO: rd_mux[15:0] = offset_word_lo;
      acdp_pkg::ADDR_GAIN_HI: rd_mux[15:0] = gain_word_hi;
      acdp_pkg::ADDR_GAIN_LO: rd_mux[15:0] = gain_word_lo;
      acdp_pkg::ADDR_RESULT: rd_mux = 32'(conv_data);
      acdp_pkg::ADDR_IRQ_STAT: rd_mux[1:0] = irq_stat;
      acdp_pkg::ADDR_IRQ_MASK: rd_mux[1:0] = irq_mask;
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_comb begin
    next_bus_state = acdp_pkg::ACDP_IDLE;
    next_readdata = readdata;
    if (bus_state == acdp_pkg::ACDP_IDLE && (avs.read | avs.write)) begin
      next_bus_state = acdp_pkg::ACDP_ACK;
      next_readdata = avs.read ? rd_mux : 32'h0000_0000;
    end
    next_ctrl = ctrl;
    next_offset_word_hi = offset_word_hi;
    next_offset_word_lo = offset_word_lo;
    next_gain_word_hi = gain_word_hi;
    next_gain_word_lo = gain_word_lo;
    next_irq_mask = irq_mask;
    next_irq_stat = irq_stat;
    if (wr_go) begin
      unique case (avs.address)
        acdp_pkg::ADDR_CTRL: next_ctrl =
          acdp_pkg::acdp_ctrl_t'(wr_merged[acdp_pkg::CTL_W-1:0]);
        acdp_pkg::ADDR_OFS_HI: next_offset_word_hi = wr_merged[15:0];
        acdp_pkg::ADDR_OFS_LO: next_offset_word_lo = wr_merged[15:0];
        acdp_pkg::ADDR_GAIN_HI: next_gain_word_hi = wr_merged[15:0];
        acdp_pkg::ADDR_GAIN_LO: next_gain_word_lo = wr_merged[15:0];
        acdp_pkg::ADDR_IRQ_MASK: next_irq_mask = wr_merged[1:0];
        default: next_ctrl = ctrl;
      endcase
    end
    // Clears only the bits returned, so a late event is not lost
    if (rd_go && avs.address == acdp_pkg::ADDR_IRQ_STAT) begin
      next_irq_stat = irq_stat & ~readdata[1:0];
    end
    next_irq_stat = next_irq_stat | irq_set;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      bus_state <= acdp_pkg::ACDP_IDLE;
      readdata <= 32'h0000_0000;
      ctrl <= acdp_pkg::acdp_ctrl_t'(acdp_pkg::CTRL_RST);
      offset_word_hi <= acdp_pkg::OFS_RST[31:16];
      offset_word_lo <= acdp_pkg::OFS_RST[15:0];
      gain_word_hi <= acdp_pkg::GAIN_RST[31:16];
      gain_word_lo <= acdp_pkg::GAIN_RST[15:0];
      irq_stat <= acdp_pkg::IRQ_RST;
      irq_mask <= acdp_pkg::IRQ_RST;
    end else begin
      bus_state <= next_bus_state;
      readdata <= next_readdata;
      ctrl <= next_ctrl;
      offset_word_hi <= next_offset_word_hi;
      offset_word_lo <= next_offset_word_lo;
      gain_word_hi <= next_gain_word_hi;
      gain_word_lo <= next_gain_word_lo;
      irq_stat <= next_irq_stat;
      irq_mask <= next_irq_mask;
    end
  end

  // ****************************************
  // Offset stage
  // ****************************************
  logic s1_valid, next_s1_valid;
  acdp_pkg::acdp_res_t s1_res, next_s1_res;
  logic signed [acdp_pkg::CORR_W-1:0] s1_corr, next_s1_corr;
  logic signed [acdp_pkg::CORR_W-1:0] ofs_term;

  always_comb begin
    ofs_term = acdp_pkg::CORR_W'(offset_val) <<< ofs_shift(ctrl.res);
    if (ctrl.input_chopping_mode) begin
      ofs_term = '0;
    end
    next_s1_valid = filt.valid;
    next_s1_res = filt.valid ? ctrl.res : s1_res;
    next_s1_corr = filt.valid ?
      acdp_pkg::CORR_W'(filt.data) - ofs_term : s1_corr;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      s1_valid <= 1'b0;
      s1_res <= acdp_pkg::ACDP_RES24;
      s1_corr <= '0;
    end else begin
      s1_valid <= next_s1_valid;
      s1_res <= next_s1_res;
      s1_corr <= next_s1_corr;
    end
  end

  // ****************************************
  // Gain stage
  // ****************************************
  logic m_valid;
  logic [1:0] m_tag;
  logic signed [acdp_pkg::PROD_W-1:0] m_prod;
  acdp_pkg::acdp_res_t m_res;
  logic signed [acdp_pkg::SCL_W-1:0] scaled;
  acdp_mul u_mul (
    .clk(clk),
    .srst(srst),
    .in_valid(s1_valid),
    .in_tag(s1_res),
    .a(s1_corr),
    .b(gain_val),
    .out_valid(m_valid),
    .out_tag(m_tag),
    .p(m_prod)
  );
  assign m_res = acdp_pkg::acdp_res_t'(m_tag);
  assign scaled = m_prod[acdp_pkg::PROD_W-1:acdp_pkg::DIV_SHIFT];

  // ****************************************
  // Range check and result store
  // ****************************************
  logic next_conv_done, next_ovf;
  logic signed [acdp_pkg::RES_W-1:0] next_conv_data;
  logic next_swap;
  logic hi_ovf, lo_ovf;
  assign hi_ovf = scaled > acdp_pkg::SCL_W'(lim_max(m_res));
  assign lo_ovf = scaled < acdp_pkg::SCL_W'(lim_min(m_res));
  always_comb begin
    next_conv_done = m_valid;
    next_ovf = range_overflow_flag;
    next_conv_data = conv_data;
    if (m_valid) begin
      next_ovf = hi_ovf | lo_ovf;
      if (hi_ovf) begin
        next_conv_data = lim_max(m_res);
      end else if (lo_ovf) begin
        next_conv_data = lim_min(m_res);
      end else begin
        next_conv_data = scaled[acdp_pkg::RES_W-1:0];
      end
    end
    irq_set = 2'h0;
    irq_set[acdp_pkg::IRQ_DONE_BIT] = m_valid;
    irq_set[acdp_pkg::IRQ_OVF_BIT] = m_valid & (hi_ovf | lo_ovf);
    next_swap = ctrl.iex & ctrl.input_chopping_mode & input_chopping_mode_phase;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      conv_done <= 1'b0;
      range_overflow_flag <= 1'b0;
      conv_data <= '0;
      excitation_swap <= 1'b0;
    end else begin
      conv_done <= next_conv_done;
      range_overflow_flag <= next_ovf;
      conv_data <= next_conv_data;
      excitation_swap <= next_swap;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  sequence s_take;
    filt.valid;
  endsequence
  sequence s_finish;
    ##3 conv_done;
  endsequence
  property p_raw_in;
    filt.valid && ctrl.input_chopping_mode |=>
      s1_corr == acdp_pkg::CORR_W'($past(filt.data));
  endproperty
  a_raw_in: assert property (p_raw_in)
    else $error("input_chopping_mode input not passed unchanged");
  property p_ofs20;
    filt.valid && !ctrl.input_chopping_mode && ctrl.res == acdp_pkg::ACDP_RES20 |=>
      s1_corr == acdp_pkg::CORR_W'($past(filt.data))
        - (acdp_pkg::CORR_W'($past(offset_val)) * 64);
  endproperty
  a_ofs20: assert property (p_ofs20)
    else $error("20-bit offset term wrong");
  property p_ofs24;
    filt.valid && !ctrl.input_chopping_mode && ctrl.res == acdp_pkg::ACDP_RES24 |=>
      s1_corr == acdp_pkg::CORR_W'($past(filt.data))
        - (acdp_pkg::CORR_W'($past(offset_val)) * 4);
  endproperty
  a_ofs24: assert property (p_ofs24)
    else $error("24-bit offset term wrong");
  property p_ofs16;
    filt.valid && !ctrl.input_chopping_mode && ctrl.res == acdp_pkg::ACDP_RES16 |=>
      s1_corr == acdp_pkg::CORR_W'($past(filt.data))
        - (acdp_pkg::CORR_W'($past(offset_val)) * 256);
  endproperty
  a_ofs16: assert property (p_ofs16)
    else $error("16-bit offset term wrong");
  property p_gain;
    s1_valid |=> m_valid &&
      m_prod == $past(s1_corr) * $signed({1'b0, $past(gain_val)});
  endproperty
  a_gain: assert property (p_gain)
    else $error("gain product wrong");
  property p_latency;
    s_take |-> s_finish;
  endproperty
  a_latency: assert property (p_latency)
    else $error("result not stored three cycles after sample");
  property p_in_range;
    m_valid && !hi_ovf && !lo_ovf |=> !range_overflow_flag &&
      conv_data == $past(scaled[acdp_pkg::RES_W-1:0]);
  endproperty
  a_in_range: assert property (p_in_range)
    else $error("in-range result or flag wrong");
  property p_sat_hi;
    m_valid && hi_ovf |=> range_overflow_flag &&
      conv_data == lim_max($past(m_res));
  endproperty
  a_sat_hi: assert property (p_sat_hi)
    else $error("high clamp or flag wrong");
  property p_sat_lo;
    m_valid && lo_ovf |=> range_overflow_flag &&
      conv_data == lim_min($past(m_res));
  endproperty
  a_sat_lo: assert property (p_sat_lo)
    else $error("low clamp or flag wrong");
  property p_lim20;
    conv_done && $past(m_res) == acdp_pkg::ACDP_RES20 |->
      conv_data <= acdp_pkg::MAX20 && conv_data >= acdp_pkg::MIN20;
  endproperty
  a_lim20: assert property (p_lim20)
    else $error("20-bit result outside range");
  property p_swap;
    ##1 excitation_swap ==
      $past(ctrl.iex && ctrl.input_chopping_mode && input_chopping_mode_phase);
  endproperty
  a_swap: assert property (p_swap)
    else $error("excitation swap out of step");
  // A pending status read may clear in either of the next two cycles
  property p_irq_sticky;
    conv_done && !(avs.read && avs.address == acdp_pkg::ADDR_IRQ_STAT)
      |=> irq_stat[acdp_pkg::IRQ_DONE_BIT] [*2];
  endproperty
  a_irq_sticky: assert property (p_irq_sticky)
    else $error("done status not held");
endmodule // acdp_core

/* pkg/acdp_pkg.sv */
// Constants, layouts and types of the calibration datapath.
// Assumes a single 250 MHz clock and an Avalon-MM master.
package acdp_pkg;
  // ****************************************
  // Widths
  // ****************************************
  localparam int IN_W = 26;
  localparam int OFS_W = 32;
  localparam int GAIN_W = 32;
  localparam int CORR_W = 41;
  localparam int PROD_W = 74;
  localparam int DIV_SHIFT = 24;
  localparam int SCL_W = 50;
  localparam int RES_W = 24;
  localparam int HALF_W = 16;
  localparam logic [IN_W-1:0] FULL_SCALE = 26'h100_0000;
  // ****************************************
  // Offset scaling and limits
  // ****************************************
  localparam logic [3:0] OFS_SHIFT16 = 4'h8;
  localparam logic [3:0] OFS_SHIFT20 = 4'h6;
  localparam logic [3:0] OFS_SHIFT24 = 4'h2;
  localparam logic signed [RES_W-1:0] MAX16 = 24'h00_7fff;
  localparam logic signed [RES_W-1:0] MIN16 = 24'hff_8000;
  localparam logic signed [RES_W-1:0] MAX20 = 24'h07_ffff;
  localparam logic signed [RES_W-1:0] MIN20 = 24'hf8_0000;
  localparam logic signed [RES_W-1:0] MAX24 = 24'h7f_ffff;
  localparam logic signed [RES_W-1:0] MIN24 = 24'h80_0000;
  // ****************************************
  // Register map and fields
  // ****************************************
  localparam logic [5:0] ADDR_CTRL = 6'h00;
  localparam logic [5:0] ADDR_STAT = 6'h04;
  localparam logic [5:0] ADDR_OFS_HI = 6'h08;
  localparam logic [5:0] ADDR_OFS_LO = 6'h0c;
  localparam logic [5:0] ADDR_GAIN_HI = 6'h10;
  localparam logic [5:0] ADDR_GAIN_LO = 6'h14;
  localparam logic [5:0] ADDR_RESULT = 6'h18;
  localparam logic [5:0] ADDR_IRQ_STAT = 6'h1c;
  localparam logic [5:0] ADDR_IRQ_MASK = 6'h20;
  localparam int CTL_W = 4;
  localparam int STAT_OVF_BIT = 0;
  localparam int IRQ_DONE_BIT = 0;
  localparam int IRQ_OVF_BIT = 1;
  localparam logic [3:0] CTRL_RST = 4'h2;
  localparam logic [OFS_W-1:0] OFS_RST = 32'h0000_0000;
  localparam logic [GAIN_W-1:0] GAIN_RST = 32'h0100_0000;
  localparam logic [1:0] IRQ_RST = 2'h0;
  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [1:0] {
    ACDP_RES16, ACDP_RES20, ACDP_RES24, ACDP_RES_RSVD
  } acdp_res_t;
  typedef struct packed {
    logic iex;
    logic input_chopping_mode;
    acdp_res_t res;
  } acdp_ctrl_t;
  typedef struct packed {
    logic valid;
    logic signed [IN_W-1:0] data;
  } acdp_filt_t;
  typedef struct packed {
    logic read;
    logic write;
    logic [5:0] address;
    logic [31:0] writedata;
    logic [3:0] byteenable;
  } acdp_avl_req_t;
  typedef enum logic {ACDP_IDLE, ACDP_ACK} acdp_bus_t;
endpackage

/* logic/acdp_mul.sv */
// Registered signed-by-unsigned multiplier stage with a tag.
// Assumes operands are stable in the cycle in_valid is high.
module acdp_mul (
  input wire logic clk,
  input wire logic srst,
  input wire logic in_valid,
  input wire logic [1:0] in_tag,
  input wire logic signed [acdp_pkg::CORR_W-1:0] a,
  input wire logic [acdp_pkg::GAIN_W-1:0] b,
  output logic out_valid,
  output logic [1:0] out_tag,
  output logic signed [acdp_pkg::PROD_W-1:0] p
);
  logic next_out_valid;
  logic [1:0] next_out_tag;
  logic signed [acdp_pkg::PROD_W-1:0] next_p;

  always_comb begin
    next_out_valid = in_valid;
    next_out_tag = in_valid ? in_tag : out_tag;
    // Gain is positive: zero-extended so the product stays signed
    next_p = in_valid ? a * $signed({1'b0, b}) : p;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      out_valid <= 1'b0;
      out_tag <= 2'h0;
      p <= '0;
    end else begin
      out_valid <= next_out_valid;
      out_tag <= next_out_tag;
      p <= next_p;
    end
  end
endmodule // acdp_mul

/* test/acdp_filter_model.sv */
// Partner model: decimation filter feeding samples and input_chopping_mode phase.
// Assumes the bench calls its tasks and that clk is the datapath clock.
module acdp_filter_model (
  input wire logic clk,
  output acdp_pkg::acdp_filt_t filt,
  output logic input_chopping_mode_phase
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    filt = '0;
    input_chopping_mode_phase = 1'b0;
  end
  // ****************************************
  // Sample delivery
  // ****************************************
  // full scale words
  // One-cycle valid; data then inverted so a stale word never passes
  task automatic send(input logic signed [acdp_pkg::IN_W-1:0] d);
    @(posedge clk);
    filt.valid <= 1'b1;
    filt.data <= d;
    @(posedge clk);
    filt.valid <= 1'b0;
    filt.data <= ~d;
  endtask
  task automatic set_phase(input logic ph);
    @(posedge clk);
    input_chopping_mode_phase <= ph;
  endtask
endmodule // acdp_filter_model

/* test/adc_calibration_datapath_bench.sv */
// Self-checking bench of the calibration datapath core.
// Assumes acdp_pkg is compiled first; one 250 MHz clock.
module adc_calibration_datapath_bench;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0;
  logic srst = 1'b1;
  acdp_pkg::acdp_avl_req_t avs = '{byteenable: 4'hf, default: '0};
  acdp_pkg::acdp_filt_t filt;
  logic input_chopping_mode_phase, waitrequest, conv_done, ovf, swap, irq;
  logic [31:0] readdata;
  logic signed [23:0] conv_data;
  int errors = 0;
  int checks_done = 0;
  logic signed [31:0] ofs_v = 32'hffff_fffd;
  logic [31:0] gain_v = 32'h0180_0001;
  logic [24:0] e;
  logic signed [25:0] smp [6] = '{26'h000_2711, 26'h3ff_d8ef,
    26'h01e_8481, 26'h3e1_7b7f, 26'h0ff_ffff, 26'h300_0000};
  always #2 clk = ~clk;
  acdp_filter_model i_model (.clk(clk), .filt(filt), .input_chopping_mode_phase(input_chopping_mode_phase));
  acdp_core i_dut (.clk(clk), .srst(srst), .filt(filt),
    .input_chopping_mode_phase(input_chopping_mode_phase), .avs(avs), .readdata(readdata),
    .waitrequest(waitrequest), .conv_data(conv_data), .conv_done(conv_done),
    .range_overflow_flag(ovf), .excitation_swap(swap), .irq(irq));
  // ****************************************
  // Helpers
  // ****************************************
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic hung(input string what);
    errors++;
    $display("CHECK FAILED %s expected answer seen none", what);
    summarize();
  endtask
  // Holds the request until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [5:0] a,
                     input logic [31:0] wd, output logic [31:0] rd);
    int n;
    @(posedge clk);
    avs <= '{read: !wr, write: wr, address: a, writedata: wd,
      byteenable: 4'hf};
    for (n = 0; n < 20; n++) begin
      @(posedge clk);
      if (waitrequest === 1'b0) break;
    end
    rd = readdata;
    avs.read <= 1'b0;
    avs.write <= 1'b0;
    if (n == 20) hung("waitrequest");
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask
  task automatic rd_chk(input string what, input logic [5:0] a,
                        input logic [31:0] exp);
    logic [31:0] x;
    bus(1'b0, a, 32'h0000_0000, x);
    check(what, x, exp);
  endtask
  function automatic logic [24:0] calc(input logic signed [25:0] d,
                                       input logic [1:0] r, input logic ch);
    logic signed [79:0] c, p, hi;
    c = d;
    if (!ch) c = c - (ofs_v <<< (r == 2'h0 ? acdp_pkg::OFS_SHIFT16 :
      r == 2'h1 ? acdp_pkg::OFS_SHIFT20 : acdp_pkg::OFS_SHIFT24));
    p = (c * $signed({48'h0000_0000_0000, gain_v})) >>> 24;
    hi = r == 2'h0 ? 80'h7fff : r == 2'h1 ? 80'h7_ffff : 80'h7f_ffff;
    if (p > hi) return {1'b1, hi[23:0]};
    if (p < -hi - 1) return {1'b1, 24'(-hi - 1)};
    return {1'b0, p[23:0]};
  endfunction
  // Sends one sample and judges latency, result and flag
  task automatic sample(input logic signed [25:0] d, input logic [24:0] x);
    int n;
    i_model.send(d);
    for (n = 1; n < 12; n++) begin
      @(posedge clk);
      if (conv_done === 1'b1) break;
    end
    if (n == 12) hung("conv_done");
    check("latency", n, 3);
    check("conv_data", {8'h00, conv_data}, {8'h00, x[23:0]});
    check("overflow flag", {31'h0, ovf}, {31'h0, x[24]});
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset_values();
    rd_chk("ctrl", acdp_pkg::ADDR_CTRL, 32'h0000_0002);
    rd_chk("offset hi", acdp_pkg::ADDR_OFS_HI, 32'h0000_0000);
    rd_chk("gain hi", acdp_pkg::ADDR_GAIN_HI, 32'h0000_0100);
    rd_chk("gain lo", acdp_pkg::ADDR_GAIN_LO, 32'h0000_0000);
    rd_chk("irq mask", acdp_pkg::ADDR_IRQ_MASK, 32'h0000_0000);
    rd_chk("unmapped", 6'h3c, 32'h0000_0000);
    $display("test reset_values done");
  endtask
  // Every resolution code, with and without chopping, both limits
  task automatic t_modes();
    wr(acdp_pkg::ADDR_OFS_HI, {16'h0000, ofs_v[31:16]});
    wr(acdp_pkg::ADDR_OFS_LO, {16'h0000, ofs_v[15:0]});
    wr(acdp_pkg::ADDR_GAIN_HI, {16'h0000, gain_v[31:16]});
    wr(acdp_pkg::ADDR_GAIN_LO, {16'h0000, gain_v[15:0]});
    for (int r = 0; r < 4; r++) begin
      for (int c = 0; c < 2; c++) begin
        wr(acdp_pkg::ADDR_CTRL, {29'h0, c[0], r[1:0]});
        foreach (smp[s]) begin
          e = calc(smp[s], r[1:0], c[0]);
          sample(smp[s], e);
        end
      end
    end
    rd_chk("result reg", acdp_pkg::ADDR_RESULT, 32'(signed'(e[23:0])));
    rd_chk("status", acdp_pkg::ADDR_STAT, {31'h0, e[24]});
    $display("test modes done");
  endtask
  task automatic t_irq();
    wr(acdp_pkg::ADDR_IRQ_MASK, 32'h0000_0002);
    rd_chk("irq stat old", acdp_pkg::ADDR_IRQ_STAT, 32'h0000_0003);
    // Clear lands at the edge that ends the read
    @(posedge clk);
    check("irq cleared", {31'h0, irq}, 32'h0000_0000);
    wr(acdp_pkg::ADDR_CTRL, 32'h0000_0001);
    sample(smp[4], calc(smp[4], 2'h1, 1'b0));
    check("irq raised", {31'h0, irq}, 32'h0000_0001);
    rd_chk("irq stat", acdp_pkg::ADDR_IRQ_STAT, 32'h0000_0003);
    sample(smp[0], calc(smp[0], 2'h1, 1'b0));
    check("irq masked", {31'h0, irq}, 32'h0000_0000);
    $display("test irq done");
  endtask
  // Swap follows phase only with chopping set; swap mode held set in both runs
  task automatic t_swap();
    for (int m = 0; m < 2; m++) begin
      wr(acdp_pkg::ADDR_CTRL, m ? 32'h0000_000e : 32'h0000_000a);
      for (int ph = 0; ph < 2; ph++) begin
        i_model.set_phase(ph[0]);
        repeat (2) @(posedge clk);
        check("swap", {31'h0, swap}, {31'h0, ph[0] & m[0]});
      end
      e = calc(smp[2], 2'h2, m[0]);
      sample(smp[2], e);
    end
    $display("test swap done");
  endtask
  initial begin
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    t_reset_values();
    t_modes();
    t_irq();
    t_swap();
    summarize();
  end
endmodule // adc_calibration_datapath_bench
